/* logic/host_bus_interface_decode.sv */
// host parallel bus decoder for the display controller
// Overview of operation
// - port: straps, upper address, select, 8-bit data, read/write/address strobes, chip select
// - upper three strap bits choose generic, enable-strobe or data-strobe protocol
// - generic: sel1 rd0 wr1 read; sel0 wr0 data write; sel1 wr0 command
// - enable-strobe, enable high: sel1 rw1 read; sel0 rw0 data; sel1 rw0 command
// - data-strobe, lower strobe low: same decode as enable-strobe
`timescale 1ns/1ps
module host_bus_interface_decode
  import host_bus_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ADDR_HI_W
)(
  input  wire logic [STRAP_W-1:0] bus_style_straps,
  input  wire logic [AW-1:0]      addr_hi,
  input  wire logic               command_data_select,
  input  wire logic [DW-1:0]      data_in,
  output logic      [DW-1:0]      data_out,
  output logic                    data_oe,
  input  wire logic               read_strobe_n,
  input  wire logic               write_strobe_n,
  input  wire logic               address_latch_strobe,
  input  wire logic               chip_select_n,
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic [DW-1:0]      read_data,
  output logic                    read_active,
  output logic                    read_start,
  output logic                    data_write,
  output logic                    cmd_write,
  output logic [DW-1:0]           write_data,
  output logic [AW-1:0]           write_addr_hi,
  output logic [1:0]              bus_style
);
  localparam int SW = AW + DW + 5;

  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  assign raw = {addr_hi, data_in, command_data_select, read_strobe_n,
                write_strobe_n, address_latch_strobe, chip_select_n};

  pin_sync #(.WIDTH(SW)) u_sync (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .pin_in       (raw),
    .pin_sync_out (syn)
  );

  logic [STRAP_W-1:0] strap_s;
  pin_sync #(.WIDTH(STRAP_W)) u_strap_sync (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .pin_in       (bus_style_straps),
    .pin_sync_out (strap_s)
  );

  logic [AW-1:0] s_addr;
  logic [DW-1:0] s_data;
  logic          s_sel;
  logic          s_rd_n;
  logic          s_wr_n;
  logic          s_as;
  logic          s_cs_n;
  assign {s_addr, s_data, s_sel, s_rd_n, s_wr_n, s_as, s_cs_n} = syn;

  // decode one set of synchronised pin levels into a cycle kind
  function automatic cycle_kind_t decode(bus_style_t st, logic sel, logic rd_n, logic wr_n, logic cs_n);
    cycle_kind_t k;
    k = CYC_NONE;
    if (!cs_n)
    begin
      unique case (st)
        BUS_GENERIC:
        begin
          if (sel && !rd_n && wr_n)
            k = CYC_READ;
          else if (!sel && rd_n && !wr_n)
            k = CYC_DATA_WRITE;
          else if (sel && rd_n && !wr_n)
            k = CYC_CMD_WRITE;
        end
        // rd pin is the enable (E) or the lower strobe, wr pin the r/w level
        BUS_ENABLE, BUS_DSTROBE:
        begin
          if ((st == BUS_ENABLE) ? rd_n : !rd_n)
          begin
            if (sel && wr_n)
              k = CYC_READ;
            else if (!sel && !wr_n)
              k = CYC_DATA_WRITE;
            else if (sel && !wr_n)
              k = CYC_CMD_WRITE;
          end
        end
        BUS_OFF:
          k = CYC_NONE;
      endcase
    end
    return k;
  endfunction

  // straps latched once the synchroniser has refilled after reset; later changes ignored
  localparam int                  SETTLE_W   = $clog2(SYNC_STAGES + 1);
  localparam logic [SETTLE_W-1:0] SETTLE_END = SETTLE_W'(SYNC_STAGES);

  logic                strap_done_r;
  logic                strap_done_nxt;
  logic [SETTLE_W-1:0] settle_r;
  logic [SETTLE_W-1:0] settle_nxt;
  bus_style_t          style_r;
  bus_style_t          style_nxt;

  always_comb
  begin
    strap_done_nxt = strap_done_r;
    style_nxt      = style_r;
    settle_nxt     = settle_r;
    // reset clears the synchroniser, so an early latch would always see code zero
    if (settle_r != SETTLE_END)
      settle_nxt = settle_r + SETTLE_W'(1);
    else if (!strap_done_r)
    begin
      strap_done_nxt = 1'b1;
      unique case (strap_s[STYLE_LSB +: STYLE_W])
        STYLE_GENERIC: style_nxt = BUS_GENERIC;
        STYLE_ENABLE:  style_nxt = BUS_ENABLE;
        STYLE_DSTROBE: style_nxt = BUS_DSTROBE;
        default:       style_nxt = BUS_OFF;
      endcase
    end
    if (rst)
    begin
      strap_done_nxt = 1'b0;
      style_nxt      = BUS_OFF;
      settle_nxt     = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    strap_done_r <= strap_done_nxt;
    settle_r     <= settle_nxt;
    style_r      <= style_nxt;
  end

  cycle_kind_t kind;
  assign kind = strap_done_r ? decode(style_r, s_sel, s_rd_n, s_wr_n, s_cs_n) : CYC_NONE;

  cycle_kind_t kind_prev_r;
  cycle_kind_t kind_prev_nxt;
  logic [DW-1:0] dout_r;
  logic [DW-1:0] dout_nxt;
  logic          oe_r;
  logic          oe_nxt;
  logic          rstart_r;
  logic          rstart_nxt;
  logic          dwr_r;
  logic          dwr_nxt;
  logic          cwr_r;
  logic          cwr_nxt;
  logic [DW-1:0] wdat_r;
  logic [DW-1:0] wdat_nxt;
  logic [AW-1:0] wadr_r;
  logic [AW-1:0] wadr_nxt;

  // write data captured on every clock of a write cycle, so the settled value from its last clock is kept
  always_comb
  begin
    kind_prev_nxt = kind;
    oe_nxt        = (kind == CYC_READ);
    dout_nxt      = (kind == CYC_READ) ? read_data : '0;
    rstart_nxt    = (kind == CYC_READ) && (kind_prev_r != CYC_READ);
    dwr_nxt       = (kind_prev_r == CYC_DATA_WRITE) && (kind != CYC_DATA_WRITE);
    cwr_nxt       = (kind_prev_r == CYC_CMD_WRITE) && (kind != CYC_CMD_WRITE);
    wdat_nxt      = wdat_r;
    wadr_nxt      = wadr_r;
    if (kind == CYC_DATA_WRITE || kind == CYC_CMD_WRITE)
    begin
      wdat_nxt = s_data;
      wadr_nxt = s_as ? s_addr : wadr_r;
    end
    if (rst)
    begin
      kind_prev_nxt = CYC_NONE;
      oe_nxt        = 1'b0;
      dout_nxt      = '0;
      rstart_nxt    = 1'b0;
      dwr_nxt       = 1'b0;
      cwr_nxt       = 1'b0;
      wdat_nxt      = '0;
      wadr_nxt      = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    kind_prev_r <= kind_prev_nxt;
    oe_r        <= oe_nxt;
    dout_r      <= dout_nxt;
    rstart_r    <= rstart_nxt;
    dwr_r       <= dwr_nxt;
    cwr_r       <= cwr_nxt;
    wdat_r      <= wdat_nxt;
    wadr_r      <= wadr_nxt;
  end

  assign data_out      = dout_r;
  assign data_oe       = oe_r;
  assign read_active   = oe_r;
  assign read_start    = rstart_r;
  assign data_write    = dwr_r;
  assign cmd_write     = cwr_r;
  assign write_data    = wdat_r;
  assign write_addr_hi = wadr_r;
  assign bus_style     = style_r;

  chk_oe_only_read: assert property (@(posedge ref_clk) disable iff (rst)
    data_oe |-> $past(kind) == CYC_READ) else $error("data driven outside read");
  chk_cs_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    s_cs_n |=> !data_oe) else $error("drive while deselected");
  chk_generic_cmd: assert property (@(posedge ref_clk) disable iff (rst)
    (style_r == BUS_GENERIC && strap_done_r && !s_cs_n && s_sel && s_rd_n && !s_wr_n)
    ##1 (!s_cs_n && s_wr_n) |=> cmd_write) else $error("generic command missed");
  chk_enable_read: assert property (@(posedge ref_clk) disable iff (rst)
    (style_r == BUS_ENABLE && strap_done_r && !s_cs_n && s_rd_n && s_sel && s_wr_n)
    |=> data_oe) else $error("enable read missed");
  chk_dstrobe_data: assert property (@(posedge ref_clk) disable iff (rst)
    (style_r == BUS_DSTROBE && strap_done_r && !s_cs_n && !s_rd_n && !s_sel && !s_wr_n)
    ##1 s_cs_n |=> data_write) else $error("strobe data write missed");
  chk_style_stable: assert property (@(posedge ref_clk) disable iff (rst)
    strap_done_r |=> $stable(style_r)) else $error("bus style changed");
  chk_write_excl: assert property (@(posedge ref_clk) disable iff (rst)
    !(data_write && cmd_write)) else $error("both write pulses");
  chk_write_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    data_write |=> !data_write) else $error("write pulse too long");
  cov_read: cover property (@(posedge ref_clk) read_start);
  cov_dwrite: cover property (@(posedge ref_clk) data_write);
  cov_cwrite: cover property (@(posedge ref_clk) cmd_write);
endmodule // host_bus_interface_decode

/* logic/host_bus_pkg.sv */
// constants and types for the host bus decoder
package host_bus_pkg;
  localparam int DATA_W       = 8;
  localparam int ADDR_HI_W    = 15;
  localparam int STRAP_W      = 5;
  localparam int STYLE_LSB    = 2;
  localparam int STYLE_W      = 3;
  localparam int SYNC_STAGES  = 2;
  // bus style codes on the upper strap bits
  localparam logic [2:0] STYLE_GENERIC = 3'h0;
  localparam logic [2:0] STYLE_ENABLE  = 3'h1;
  localparam logic [2:0] STYLE_DSTROBE = 3'h2;

  typedef enum logic [1:0] {
    CYC_NONE,
    CYC_READ,
    CYC_DATA_WRITE,
    CYC_CMD_WRITE
  } cycle_kind_t;

  typedef enum logic [1:0] {
    BUS_GENERIC,
    BUS_ENABLE,
    BUS_DSTROBE,
    BUS_OFF
  } bus_style_t;
endpackage

/* logic/pin_sync.sv */
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync
  import host_bus_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    if (rst)
    begin
      meta_nxt = '0;
      sync_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign pin_sync_out = sync_r;
endmodule // pin_sync

/* tb/host_bus_interface_decode_tb.sv */
// self-checking bench for the host bus decoder
`timescale 1ns/1ps
module host_bus_interface_decode_tb;
  import host_bus_pkg::*;
  logic                 ref_clk = 1'b0;
  logic                 rst = 1'b1;
  logic [DATA_W-1:0]    read_data = 8'h00;
  logic [STRAP_W-1:0]   straps;
  logic [ADDR_HI_W-1:0] addr_hi, write_addr_hi;
  logic [DATA_W-1:0]    data_in, data_out, write_data;
  logic                 sel, rd_n, wr_n, als, cs_n, data_oe, read_active, read_start, data_write, cmd_write;
  logic [1:0]           bus_style;
  logic [15:0]          last_wd, last_wa;
  int                   errors = 0, tests_run = 0, n_dw, n_cw, n_rs, n_oe;

  host_cpu_model host(.ref_clk, .bus_style_straps(straps), .addr_hi, .command_data_select(sel), .data_in,
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .address_latch_strobe(als), .chip_select_n(cs_n));

  host_bus_interface_decode dut(.bus_style_straps(straps), .addr_hi, .command_data_select(sel), .data_in,
    .data_out, .data_oe, .read_strobe_n(rd_n), .write_strobe_n(wr_n), .address_latch_strobe(als),
    .chip_select_n(cs_n), .ref_clk, .rst, .read_data, .read_active, .read_start, .data_write, .cmd_write,
    .write_data, .write_addr_hi, .bus_style);

  always #25 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(negedge ref_clk)
  begin
    if (data_oe === 1'b1)
    begin
      n_oe++;
      check("data_out", 16'(read_data), 16'(data_out));
    end
    check("read_active", 16'(data_oe), 16'(read_active));
    n_rs += int'(read_start === 1'b1);
    n_dw += int'(data_write === 1'b1);
    n_cw += int'(cmd_write === 1'b1);
    if (data_write === 1'b1 || cmd_write === 1'b1)
    begin
      last_wd = 16'(write_data);
      last_wa = 16'(write_addr_hi);
    end
  end

  initial
  begin
    logic [2:0] styles [4];
    cycle_kind_t k;
    logic [DATA_W-1:0] d;
    logic [ADDR_HI_W-1:0] a;
    logic on, go, early;
    styles = '{3'h0, 3'h1, 3'h2, 3'h5};
    void'($urandom(32'hF306A147));
    foreach (styles[s])
    begin
      rst = 1'b1;
      host.set_style(styles[s]);
      repeat (6) @(negedge ref_clk);
      check("bus_style in reset", 16'h0003, 16'(bus_style));
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
      on = (styles[s] < 3'h3);
      check("bus_style", on ? 16'(styles[s]) : 16'h0003, 16'(bus_style));
      for (int i = 0; i < 8; i++)
      begin
        // first three fix every kind, last one has chip select idle
        k = cycle_kind_t'(i < 3 ? i + 1 : $urandom_range(3, 1));
        go = on & (i != 7);
        // even cycles drop the strobes one clock before chip select
        early = (i % 2 == 0);
        d = 8'($urandom);
        a = 15'($urandom);
        read_data = 8'($urandom);
        n_dw = 0;
        n_cw = 0;
        n_rs = 0;
        n_oe = 0;
        host.run(k, i != 7, early, d, a);
        check("read_start", 16'(go & (k == CYC_READ)), 16'(n_rs));
        // drive lasts as long as the read strobe, three clocks late
        check("data driven cycles", 16'((go && k == CYC_READ) ? 5 - int'(early) : 0), 16'(n_oe));
        check("data_write", 16'(go & (k == CYC_DATA_WRITE)), 16'(n_dw));
        check("cmd_write", 16'(go & (k == CYC_CMD_WRITE)), 16'(n_cw));
        if (go & (k != CYC_READ))
        begin
          check("write_data", 16'(d), last_wd);
          check("write_addr_hi", 16'(a), last_wa);
        end
      end
    end
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end
endmodule // host_bus_interface_decode_tb

/* tb/host_cpu_model.sv */
// host processor model driving the parallel bus pins
`timescale 1ns/1ps
module host_cpu_model
  import host_bus_pkg::*;
(
  input  wire logic                 ref_clk,
  output logic      [STRAP_W-1:0]   bus_style_straps,
  output logic      [ADDR_HI_W-1:0] addr_hi,
  output logic                      command_data_select,
  output logic      [DATA_W-1:0]    data_in,
  output logic                      read_strobe_n,
  output logic                      write_strobe_n,
  output logic                      address_latch_strobe,
  output logic                      chip_select_n
);
  logic [2:0] style;

  task automatic idle();
    chip_select_n = 1'b1;
    read_strobe_n = (style != STYLE_ENABLE);
    write_strobe_n = 1'b1;
    address_latch_strobe = 1'b0;
    addr_hi = ~addr_hi;
    data_in = ~data_in; // released pins have no pull, so never rest on old data
  endtask

  task automatic set_style(input logic [2:0] s);
    style = s;
    bus_style_straps = {s, 2'h0};
    idle();
  endtask

  task automatic run(input cycle_kind_t kind, input logic cs, input logic early,
                     input logic [DATA_W-1:0] d, input logic [ADDR_HI_W-1:0] a);
    logic rw;
    rw = (kind == CYC_READ);
    @(negedge ref_clk);
    chip_select_n = ~cs;
    command_data_select = (kind != CYC_DATA_WRITE);
    write_strobe_n = rw;
    if (style == STYLE_GENERIC)
      read_strobe_n = ~rw;
    else
      read_strobe_n = (style == STYLE_ENABLE);
    data_in = rw ? ~data_in : d;
    addr_hi = a;
    address_latch_strobe = 1'b1;
    repeat (4) @(negedge ref_clk);
    if (early)
    begin
      // strobes drop first, chip select and address still held
      write_strobe_n = 1'b1;
      read_strobe_n = (style != STYLE_ENABLE);
    end
    @(negedge ref_clk);
    idle();
    repeat (6) @(negedge ref_clk);
  endtask

  initial
  begin
    data_in = 8'h00;
    addr_hi = '0;
    command_data_select = 1'b0;
    set_style(3'h0);
  end
endmodule // host_cpu_model
